// ### hw/ssr_consts.svh
// Offsets, field positions, reset values and counts of the slave serial receiver
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SSR_IDX_MODE     16'hFF98
`define SSR_IDX_CTRL     16'hFF9A
`define SSR_IDX_STAT     16'hFF9C
`define SSR_IDX_RDAT     16'hFF9D

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SSR_MODE_COMM    7
`define SSR_CTRL_RXEN    4
`define SSR_CTRL_CKHI    1
`define SSR_CTRL_CKLO    0
`define SSR_STAT_FULL    6
`define SSR_STAT_OVR     5
`define SSR_STAT_FRM     4
`define SSR_STAT_PAR     3

// ----------------------------------------------------------------
// Reset values, encodings and counts
// ----------------------------------------------------------------
`define SSR_RST_MODE     8'h00
`define SSR_RST_CTRL     8'h00
`define SSR_RST_RDAT     8'h00
`define SSR_CLK_EXT      2'h2
`define SSR_FRAME_BITS   8
`define SSR_SYNC_STAGES  2

`endif

// ### hw/ssr_pkg.sv
// Types shared by the slave serial receiver files
package ssr_pkg;

  // ----------------------------------------------------------------
  // Receive status flags
  // ----------------------------------------------------------------
  typedef struct packed {
    logic full;
    logic overrun;
    logic framing;
    logic parity;
  } ssr_flags_t;

  // ----------------------------------------------------------------
  // Synchronised serial pins of one channel
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sclk;
    logic sdin;
  } ssr_pins_t;

  // ----------------------------------------------------------------
  // Receiver control states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    st_idle,
    st_recv,
    st_halt
  } ssr_state_t;

endpackage : ssr_pkg

// ### hw/ssr_sync.sv
// Multi-bit two-stage synchroniser for serial pins
`timescale 1ns/1ps

module ssr_sync #(
  parameter int WIDTH  = 4,
  parameter int STAGES = 2
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (STAGES != 2 || WIDTH < 1) begin : g_bad_param
    $error("ssr_sync supports two stages and a nonzero width");
  end

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stable_r;

  // ----------------------------------------------------------------
  // Stages; first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      // Idle high level, so no false serial clock edge follows reset
      meta_r   <= '1;
      stable_r <= '1;
    end else if (clk_en) begin
      meta_r   <= async_in;
      stable_r <= meta_r;
    end
  end

  assign sync_out = stable_r;

endmodule : ssr_sync

// ### hw/ssr_shift.sv
// Serial-to-parallel receive shift register, LSB first
`timescale 1ns/1ps

module ssr_shift #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             clear,
  input  wire logic             sample,
  input  wire logic             din,
  output logic                  frame_valid,
  output logic      [WIDTH-1:0] frame_data
);

  localparam int CW = $clog2(WIDTH);

  if (WIDTH < 2) begin : g_bad_width
    $error("ssr_shift needs at least two bits per frame");
  end

  logic [WIDTH-1:0] shift_r;
  logic [CW-1:0]    count_r;
  logic             valid_r;
  logic [WIDTH-1:0] data_r;
  wire              last_bit;
  wire  [WIDTH-1:0] shifted;

  assign last_bit = (count_r == CW'(WIDTH - 1));
  assign shifted  = {din, shift_r[WIDTH-1:1]};

  // ----------------------------------------------------------------
  // Bit counter and shifter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      shift_r <= '0;
      count_r <= '0;
    end else if (clk_en) begin
      if (clear) begin
        count_r <= '0;
      end else if (sample) begin
        shift_r <= shifted;
        count_r <= last_bit ? '0 : count_r + CW'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame hand-off; shifter is free again at once
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      valid_r <= 1'b0;
      data_r  <= '0;
    end else if (clk_en) begin
      valid_r <= sample & last_bit & ~clear;
      if (sample & last_bit) begin
        data_r <= shifted;
      end
    end
  end

  assign frame_valid = valid_r;
  assign frame_data  = data_r;

endmodule : ssr_shift

// ### hw/ssr_receiver.sv
// Clock-synchronous slave serial receiver with Avalon-MM register slave
`timescale 1ns/1ps
`include "ssr_consts.svh"


module ssr_receiver #(
  parameter int PIN_SEL = 0
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        standby_mode,
  input  wire logic        serial_clk_pin_a,
  input  wire logic        serial_clk_pin_b,
  input  wire logic        serial_in_pin_a,
  input  wire logic        serial_in_pin_b,
  input  wire logic [17:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             rx_active
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (PIN_SEL != 0 && PIN_SEL != 1) begin : g_bad_pin
    $error("PIN_SEL must be 0 or 1");
  end

  localparam int FRAME_BITS = `SSR_FRAME_BITS;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [17:0] addr, input logic [15:0] idx);
    return (addr[17:2] == idx) && (addr[1:0] == 2'h0);
  endfunction : reg_hit

  // Hardware set beats a software clear in the same cycle
  function automatic logic flag_next(input logic cur, input logic set, input logic clr);
    return set | (cur & ~clr);
  endfunction : flag_next

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                   [7:0]  mode_r;
  logic                   [7:0]  ctrl_r;
  logic                   [7:0]  rdat_r;
  ssr_pkg::ssr_flags_t           flags_r;
  ssr_pkg::ssr_flags_t           flags_nxt;
  ssr_pkg::ssr_flags_t           armed_r;
  ssr_pkg::ssr_state_t           state_r;
  ssr_pkg::ssr_state_t           state_nxt;
  logic                   [31:0] readdata_r;
  logic                          waitreq_r;
  logic                          active_r;
  logic                          sclk_d_r;

  wire                    [3:0]  pins_s;
  ssr_pkg::ssr_pins_t            chan_s;
  wire                           sclk_rise;
  wire                           shift_clear;
  wire                           frame_valid;
  wire         [FRAME_BITS-1:0]  frame_data;

  wire                           req;
  wire                           acc_done;
  wire                           hit_mode;
  wire                           hit_ctrl;
  wire                           hit_stat;
  wire                           hit_rdat;
  wire                    [7:0]  wr_byte;
  wire                           wr_ok;
  wire                           wr_mode;
  wire                           wr_ctrl;
  wire                           wr_stat;
  wire                           rd_stat;
  wire                           rd_rdat;
  wire                    [7:0]  stat_byte;
  wire                    [31:0] rd_value;

  wire                           clk_ext;
  wire                           sync_mode;
  wire                           enabled;
  wire                           blocked;
  wire                           take;
  wire                           ovr_set;
  wire                           err_set;
  ssr_pkg::ssr_flags_t           clr;

  // ----------------------------------------------------------------
  // Pin synchronisers and channel select
  // ----------------------------------------------------------------
  // Synchronise pin inputs
  ssr_sync #(
    .WIDTH  (4),
    .STAGES (`SSR_SYNC_STAGES)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .async_in ({serial_clk_pin_a, serial_in_pin_a, serial_clk_pin_b, serial_in_pin_b}),
    .sync_out (pins_s)
  );

  // Clock and data share latency, so data is sampled where the edge was seen
  assign chan_s = (PIN_SEL == 0) ? pins_s[3:2] : pins_s[1:0];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sclk_d_r <= 1'b1;
    end else if (clk_en) begin
      sclk_d_r <= chan_s.sclk;
    end
  end

  assign sclk_rise = chan_s.sclk & ~sclk_d_r;

  // ----------------------------------------------------------------
  // Shift register
  // ----------------------------------------------------------------
  // Shift only while receiving
  assign shift_clear = (state_r != ssr_pkg::st_recv);

  ssr_shift #(
    .WIDTH (FRAME_BITS)
  ) u_shift (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .clk_en      (clk_en),
    .clear       (shift_clear),
    .sample      (sclk_rise),
    .din         (chan_s.sdin),
    .frame_valid (frame_valid),
    .frame_data  (frame_data)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign req      = avs_read | avs_write;
  assign acc_done = req & ~waitreq_r;
  assign hit_mode = reg_hit(avs_address, `SSR_IDX_MODE);
  assign hit_ctrl = reg_hit(avs_address, `SSR_IDX_CTRL);
  assign hit_stat = reg_hit(avs_address, `SSR_IDX_STAT);
  assign hit_rdat = reg_hit(avs_address, `SSR_IDX_RDAT);
  assign wr_byte  = avs_writedata[7:0];
  assign wr_ok    = avs_write & acc_done & avs_byteenable[0];
  assign wr_mode  = wr_ok & hit_mode;
  assign wr_ctrl  = wr_ok & hit_ctrl;
  assign wr_stat  = wr_ok & hit_stat;
  assign rd_stat  = avs_read & acc_done & hit_stat;
  assign rd_rdat  = avs_read & acc_done & hit_rdat;

  assign stat_byte = {1'b0, flags_r.full, flags_r.overrun, flags_r.framing,
                      flags_r.parity, 3'h0};

  // Unmapped addresses read as zero
  assign rd_value = hit_mode ? {24'h000000, mode_r} :
                    hit_ctrl ? {24'h000000, ctrl_r} :
                    hit_stat ? {24'h000000, stat_byte} :
                    hit_rdat ? {24'h000000, rdat_r} : 32'h00000000;

  // ----------------------------------------------------------------
  // Bus handshake: one wait cycle per access
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      waitreq_r  <= 1'b1;
      readdata_r <= 32'h00000000;
    end else if (clk_en) begin
      if (req & waitreq_r) begin
        waitreq_r  <= 1'b0;
        readdata_r <= avs_read ? rd_value : 32'h00000000;
      end else begin
        waitreq_r  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode and control registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode_r <= `SSR_RST_MODE;
      ctrl_r <= `SSR_RST_CTRL;
    end else if (clk_en) begin
      if (wr_mode) begin
        mode_r <= wr_byte;
      end
      if (wr_ctrl) begin
        ctrl_r <= wr_byte;
      end
    end
  end

  assign sync_mode = mode_r[`SSR_MODE_COMM];
  assign clk_ext   = ({ctrl_r[`SSR_CTRL_CKHI], ctrl_r[`SSR_CTRL_CKLO]} == `SSR_CLK_EXT);
  assign enabled   = sync_mode & clk_ext & ctrl_r[`SSR_CTRL_RXEN] & ~standby_mode;
  assign blocked   = flags_r.overrun | flags_r.framing | flags_r.parity;

  // ----------------------------------------------------------------
  // Receiver state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ssr_pkg::st_idle: begin
        if (enabled) begin
          state_nxt = blocked ? ssr_pkg::st_halt : ssr_pkg::st_recv;
        end
      end
      ssr_pkg::st_recv: begin
        if (!enabled) begin
          state_nxt = ssr_pkg::st_idle;
        end else if (blocked) begin
          state_nxt = ssr_pkg::st_halt;
        end
      end
      ssr_pkg::st_halt: begin
        if (!enabled) begin
          state_nxt = ssr_pkg::st_idle;
        end else if (!blocked) begin
          state_nxt = ssr_pkg::st_recv;
        end
      end
      default: begin
        state_nxt = ssr_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r  <= ssr_pkg::st_idle;
      active_r <= 1'b0;
    end else if (clk_en) begin
      state_r  <= state_nxt;
      active_r <= (state_nxt == ssr_pkg::st_recv);
    end
  end

  // ----------------------------------------------------------------
  // Frame acceptance
  // ----------------------------------------------------------------
  // Accept into empty data register
  assign take    = frame_valid & ~flags_r.full & ~blocked;
  // Overrun on frame into full register
  assign ovr_set = frame_valid & flags_r.full;
  // No parity or stop bit in synchronous mode, so no error source here
  assign err_set = 1'b0;

  // Data register reset and standby clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdat_r <= `SSR_RST_RDAT;
    end else if (clk_en) begin
      if (standby_mode) begin
        rdat_r <= `SSR_RST_RDAT;
      end else if (take) begin
        rdat_r <= frame_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Full clears by zero after read one, or by a read of the data register
  assign clr.full    = (wr_stat & armed_r.full & ~wr_byte[`SSR_STAT_FULL]) | rd_rdat;
  // Only a zero after a one read clears
  assign clr.overrun = wr_stat & armed_r.overrun & ~wr_byte[`SSR_STAT_OVR];
  assign clr.framing = wr_stat & armed_r.framing & ~wr_byte[`SSR_STAT_FRM];
  assign clr.parity  = wr_stat & armed_r.parity & ~wr_byte[`SSR_STAT_PAR];

  always_comb begin
    flags_nxt.full    = flag_next(flags_r.full, take, clr.full);
    flags_nxt.overrun = flag_next(flags_r.overrun, ovr_set, clr.overrun);
    flags_nxt.framing = flag_next(flags_r.framing, err_set, clr.framing);
    flags_nxt.parity  = flag_next(flags_r.parity, err_set, clr.parity);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flags_r <= '0;
    end else if (clk_en) begin
      flags_r <= flags_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read-one arming, taken from the value the master saw
  // ----------------------------------------------------------------
  // Arm on read of one
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      armed_r <= '0;
    end else if (clk_en) begin
      if (rd_stat) begin
        armed_r <= readdata_r[`SSR_STAT_FULL:`SSR_STAT_PAR];
      end else if (wr_stat) begin
        armed_r <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata    = readdata_r;
  assign avs_waitrequest = waitreq_r;
  assign rx_active       = active_r;

endmodule : ssr_receiver

// ### verification/ssr_receiver_asserts.sv
// Port checker for the slave serial receiver
`timescale 1ns/1ps
`include "ssr_consts.svh"

module ssr_receiver_asserts (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic        standby_mode,
  input wire logic [17:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        rx_active
);
  // --
  // Shadow state
  // --
  localparam logic [17:0] A_MODE = {`SSR_IDX_MODE, 2'h0};
  localparam logic [17:0] A_CTRL = {`SSR_IDX_CTRL, 2'h0};
  localparam logic [17:0] A_STAT = {`SSR_IDX_STAT, 2'h0};
  localparam logic [17:0] A_RDAT = {`SSR_IDX_RDAT, 2'h0};
  logic [7:0] mode_r;
  logic [7:0] ctrl_r;
  logic       zero_r;
  logic       fclr_r;
  wire rd_done = avs_read && !avs_waitrequest;
  wire wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire rdat_rd = rd_done && avs_address == A_RDAT;
  wire stat_rd = rd_done && avs_address == A_STAT;
  wire mapped  = avs_address inside {A_MODE, A_CTRL, A_STAT, A_RDAT};
  wire cfg_ok  = mode_r[`SSR_MODE_COMM] && ctrl_r[`SSR_CTRL_RXEN]
                 && ctrl_r[`SSR_CTRL_CKHI:`SSR_CTRL_CKLO] == `SSR_CLK_EXT;

  // Frames only land while receiving, so rx_active low means data is frozen
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode_r <= `SSR_RST_MODE;
      ctrl_r <= `SSR_RST_CTRL;
      zero_r <= 1'h1;
      fclr_r <= 1'h0;
    end else if (clk_en) begin
      if (wr_done && avs_address == A_MODE) mode_r <= avs_writedata[7:0];
      if (wr_done && avs_address == A_CTRL) ctrl_r <= avs_writedata[7:0];
      zero_r <= standby_mode || (zero_r && !rx_active);
      fclr_r <= rdat_rd || (fclr_r && !stat_rd && !rx_active);
    end
  end

  // --
  // Properties
  // --
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n || !clk_en);
  sequence s_take;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_wait_one_cycle: assert property (s_take |=> s_answer)
    else $error("waitrequest not low for exactly one cycle");
  a_rdat_upper_zero: assert property (rd_done |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_rdat_cleared_zero: assert property (rdat_rd && zero_r |-> avs_readdata[7:0] == `SSR_RST_RDAT)
    else $error("data register not cleared");
  a_unmapped_read_zero: assert property (rd_done && !mapped |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_cfg_gate_idle: assert property ((!cfg_ok || standby_mode) [*3] |-> !rx_active)
    else $error("receiving without valid setup");
  a_err_halt_rx: assert property (stat_rd && avs_readdata[5:3] != 3'h0 |-> ##[0:2] !rx_active)
    else $error("receiving with error flag set");
  a_full_read_clear: assert property (stat_rd && fclr_r |-> !avs_readdata[`SSR_STAT_FULL])
    else $error("full flag kept after data read");
  a_reset_quiet_outs: assert property (disable iff (1'h0) !rst_n && clk_en |=>
    avs_waitrequest && avs_readdata == 32'h0 && !rx_active)
    else $error("outputs not quiet after reset");
endmodule : ssr_receiver_asserts

bind ssr_receiver ssr_receiver_asserts u_ssr_receiver_asserts (
  .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .standby_mode(standby_mode),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_active(rx_active)
);

// ### verification/ssr_master_model.sv
// Behavioural external serial master driving clock and data
`timescale 1ns/1ps
`include "ssr_consts.svh"

module ssr_master_model #(
  parameter int HALF_NS = 40
) (
  output logic sclk,
  output logic sdin
);
  // Clock parks high between frames; data holds the last bit sent
  initial begin
    sclk = 1'h1;
    sdin = 1'h1;
  end

  task automatic send_byte(input logic [7:0] d);
    #3.1;
    for (int i = 0; i < `SSR_FRAME_BITS; i++) begin
      sclk = 1'h0;
      sdin = d[i];
      #HALF_NS;
      sclk = 1'h1;
      #HALF_NS;
    end
  endtask : send_byte
endmodule : ssr_master_model

// ### verification/tb_ssr_receiver.sv
// Bench for the slave serial receiver
`timescale 1ns/1ps
`include "ssr_consts.svh"

module tb_ssr_receiver;
  localparam logic [17:0] A_MODE = {`SSR_IDX_MODE, 2'h0};
  localparam logic [17:0] A_CTRL = {`SSR_IDX_CTRL, 2'h0};
  localparam logic [17:0] A_STAT = {`SSR_IDX_STAT, 2'h0};
  localparam logic [17:0] A_RDAT = {`SSR_IDX_RDAT, 2'h0};
  logic        core_clk;
  logic        rst_n;
  logic        clk_en;
  logic        standby_mode;
  logic        sclk;
  logic        sdin;
  logic [17:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        rx_active;
  logic [7:0]  rd_v;
  int          failures;
  int          total_checks;
  int          cycles;

  ssr_receiver #(.PIN_SEL(0)) u_ssr_receiver (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .standby_mode(standby_mode),
    .serial_clk_pin_a(sclk), .serial_clk_pin_b(1'h1), .serial_in_pin_a(sdin),
    .serial_in_pin_b(1'h1), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_active(rx_active)
  );
  ssr_master_model u_ssr_master_model (.sclk(sclk), .sdin(sdin));

  // --
  // Clock and timeout
  // --
  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  // --
  // Tasks
  // --
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  task check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  // Request held until waitrequest is sampled low
  task bus_acc(input logic is_wr, input logic [17:0] a, input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !is_wr;
    avs_write <= is_wr;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'h0);
    rd_v = avs_readdata[7:0];
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask : bus_acc

  task wr(input logic [17:0] a, input logic [7:0] d);
    bus_acc(1'h1, a, d);
  endtask : wr

  task rd_chk(input logic [17:0] a, input logic [7:0] exp);
    bus_acc(1'h0, a, 8'h00);
    check(rd_v, exp);
  endtask : rd_chk

  // Only the bench timeout ends a poll that never sees the full flag
  task poll_full;
    do begin
      bus_acc(1'h0, A_STAT, 8'h00);
    end while (rd_v[`SSR_STAT_FULL] !== 1'h1);
  endtask : poll_full

  // Frame completes within a few cycles of the last rise
  task rx_wait(input logic [7:0] d);
    u_ssr_master_model.send_byte(d);
    repeat (10) @(posedge core_clk);
  endtask : rx_wait

  // --
  // Main sequence
  // --
  initial begin
    rst_n = 1'h0;
    clk_en = 1'h1;
    standby_mode = 1'h0;
    avs_address = 18'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_byteenable = 4'hF;
    avs_writedata = 32'h0;
    failures = 0;
    total_checks = 0;
    cycles = 0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'h1;
    rd_chk(A_MODE, `SSR_RST_MODE);
    rd_chk(A_CTRL, `SSR_RST_CTRL);
    rd_chk(A_STAT, 8'h00);
    rd_chk(A_RDAT, `SSR_RST_RDAT);
    rd_chk(18'h00100, 8'h00);
    wr(A_RDAT, 8'hFF);
    rd_chk(A_RDAT, 8'h00);
    wr(A_MODE, 8'h80);
    rx_wait(8'h77);
    rd_chk(A_STAT, 8'h00);
    wr(A_CTRL, 8'h11);
    rx_wait(8'h5A);
    rd_chk(A_STAT, 8'h00);
    wr(A_CTRL, 8'h02);
    wr(A_MODE, 8'h00);
    wr(A_CTRL, 8'h12);
    rx_wait(8'h5A);
    rd_chk(A_STAT, 8'h00);
    wr(A_CTRL, 8'h02);
    wr(A_MODE, 8'h80);
    wr(A_CTRL, 8'h12);
    rd_chk(A_CTRL, 8'h12);
    rx_wait(8'hA5);
    rd_chk(A_STAT, 8'h40);
    rd_chk(A_RDAT, 8'hA5);
    rd_chk(A_STAT, 8'h00);
    // Clock enable low must freeze the receiver through a whole frame
    clk_en <= 1'h0;
    rx_wait(8'hC3);
    clk_en <= 1'h1;
    rd_chk(A_STAT, 8'h00);
    fork
      begin
        u_ssr_master_model.send_byte(8'h3C);
        u_ssr_master_model.send_byte(8'h96);
      end
    join_none
    poll_full;
    rd_chk(A_RDAT, 8'h3C);
    poll_full;
    rd_chk(A_RDAT, 8'h96);
    wait fork;
    rx_wait(8'h11);
    rd_chk(A_STAT, 8'h40);
    wr(A_STAT, 8'h00);
    rd_chk(A_STAT, 8'h00);
    rd_chk(A_RDAT, 8'h11);
    rx_wait(8'h22);
    rd_chk(A_STAT, 8'h40);
    wr(A_STAT, 8'h78);
    rd_chk(A_STAT, 8'h40);
    rx_wait(8'h44);
    rd_chk(A_STAT, 8'h60);
    rd_chk(A_RDAT, 8'h22);
    rd_chk(A_STAT, 8'h20);
    rx_wait(8'h55);
    rd_chk(A_STAT, 8'h20);
    rd_chk(A_RDAT, 8'h22);
    wr(A_CTRL, 8'h02);
    rd_chk(A_STAT, 8'h20);
    wr(A_STAT, 8'h00);
    rd_chk(A_STAT, 8'h00);
    wr(A_CTRL, 8'h12);
    rx_wait(8'h66);
    wr(A_CTRL, 8'h02);
    rd_chk(A_STAT, 8'h40);
    rd_chk(A_RDAT, 8'h66);
    @(posedge core_clk);
    standby_mode <= 1'h1;
    repeat (3) @(posedge core_clk);
    standby_mode <= 1'h0;
    rd_chk(A_RDAT, 8'h00);
    end_of_test();
  end
endmodule : tb_ssr_receiver
